// ==== rtgo_host_model.sv ====
// Host processor model that issues register accesses to the option register.
module rtgo_host_model (
  input wire logic core_clk, // Device clock.
  output rtgo_pkg::rtgo_acc_s acc // Register access toward the device.
);
  timeunit 1ns;
  timeprecision 1ns;
  import rtgo_pkg::*;
  initial acc = '0;
  // Released address and data show inverted values so stale data never looks valid.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    acc <= '{1'b1, 1'b0, a, d & 16'hffcf};
    @(posedge core_clk);
    acc <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    acc <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    acc <= '{1'b0, 1'b0, ~a, 16'hffff};
  endtask
endmodule

// ==== rtgo_option_reg.sv ====
// Remote terminal global option register and the option effects it steers.
// Contract
// - Option register at word offset 0x004D; only low bits carry options, 15..6 unused.
// - Bit 3 zero: info word bit 13 reports gap error.
// - Bit 3 one: info word bit 13 reports broadcast.
// - Busy report on and terminal busy: logged identity word gets bit 9 set.
// - Busy report on, not busy: only event flags logged, bit 9 zero.
// - Busy report off: logged bit 9 always zero.
// - Log entries only for enabled events; busy alone causes nothing.
// - Busy report never touches pending register; its bit 9 stays reserved.
// - Register holds zero after reset; all options start disabled.
module rtgo_option_reg (
  input wire logic core_clk, // Device clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; all state holds while low.
  input wire rtgo_pkg::rtgo_acc_s acc, // Host register access.
  output logic [15:0] acc_rdata, // Read data, valid the cycle after a read.
  input wire logic term_busy, // Terminal Busy status.
  input wire rtgo_pkg::rtgo_event_s evt, // Enabled interrupt event.
  output rtgo_pkg::rtgo_log_s log_out, // Log buffer write.
  input wire rtgo_pkg::rtgo_info_s info_in, // Message information word in.
  output rtgo_pkg::rtgo_info_s info_out, // Message information word out.
  input wire logic [15:0] pend_in, // Pending interrupt word from event logic.
  output logic [15:0] pend_out, // Pending interrupt word as read by the host.
  output logic ptr_hold_enable, // Option bit 1, for the buffer pointer logic.
  output logic opt0 // Option bit 0, for its user.
);
  import rtgo_pkg::*;

  logic [15:0] opt;
  logic [15:0] next_opt;
  logic [15:0] next_rdata;
  logic hit;

  assign hit = (acc.addr == RTGO_OPT_ADDR);

  always_comb
  begin
    next_opt = opt;
    next_rdata = acc_rdata;
    if (acc.wr && hit)
    begin
      // Bits 5 and 4 are stored as written; keeping them clear is software's job.
      next_opt = acc.wdata & RTGO_OPT_WMASK;
    end
    if (acc.rd)
    begin
      next_rdata = hit ? (opt & RTGO_OPT_WMASK) : 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt <= RTGO_OPT_RESET;
      acc_rdata <= 16'h0000;
    end
    else if (ce)
    begin
      opt <= next_opt;
      acc_rdata <= next_rdata;
    end
  end

  assign ptr_hold_enable = opt[RTGO_PTR_HOLD_POS];
  assign opt0 = opt[RTGO_OPT0_POS];

  rtgo_log_s next_log;
  rtgo_info_s next_info;
  logic [15:0] next_pend;

  always_comb
  begin
    next_log.write = evt.valid;
    next_log.word = evt.flags;
    // Busy status only decorates an entry; it never creates one.
    next_log.word[RTGO_BUSY_SEEN_POS] = evt.valid && opt[RTGO_BUSY_RPT_POS]
      && term_busy;
    if (!evt.valid)
    begin
      next_log.word = log_out.word;
    end
    next_info = info_in;
    next_info.word[RTGO_INFO_FLAG_POS] = opt[RTGO_BIT13_SEL_POS] ? info_in.broadcast
      : info_in.gap_error;
    if (!info_in.valid)
    begin
      next_info = info_out;
      next_info.valid = 1'b0;
    end
    next_pend = pend_in;
    next_pend[RTGO_PEND_RSVD_POS] = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      log_out <= '0;
      info_out <= '0;
      pend_out <= 16'h0000;
    end
    else if (ce)
    begin
      log_out <= next_log;
      info_out <= next_info;
      pend_out <= next_pend;
    end
  end

  // The read-back check is built from its steps: a write that hits, one cycle in which
  // no write hits, then a read that hits. Back to back traffic is legal and is left to
  // the single-step properties further down.
  sequence s_opt_write;
    ce && acc.wr && hit;
  endsequence

  sequence s_no_opt_write;
    !(ce && acc.wr && hit);
  endsequence

  sequence s_opt_read;
    ce && acc.rd && hit && !acc.wr;
  endsequence

  // An enabled event taken while the terminal is busy and busy reporting is on.
  sequence s_busy_logged;
    ce && evt.valid && term_busy && opt[RTGO_BUSY_RPT_POS];
  endsequence

  // Register bus behaviour.
  a_write_stores_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_opt_write |=> (opt == ($past(acc.wdata) & RTGO_OPT_WMASK)))
    else $error("option register did not store masked write");

  a_other_addr_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && acc.wr && !hit) |=> $stable(opt))
    else $error("write to another address changed the options");

  a_unused_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && acc.rd) |=> (acc_rdata[15:6] == 10'h000))
    else $error("unused option bits read nonzero");

  a_other_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && acc.rd && !hit) |=> (acc_rdata == 16'h0000))
    else $error("read of another address returned nonzero");

  a_read_back_value: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_opt_write ##1 s_no_opt_write ##1 s_opt_read |=>
    (acc_rdata == ($past(acc.wdata, 3) & RTGO_OPT_WMASK)))
    else $error("read back does not match the last write");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !acc.rd) |=> $stable(acc_rdata))
    else $error("read data changed without a read");

  // Message information word steering.
  a_gap_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && info_in.valid && !opt[RTGO_BIT13_SEL_POS]) |=>
    (info_out.valid && info_out.word[13] == $past(info_in.gap_error)))
    else $error("bit 13 is not the gap error flag");

  a_bcast_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && info_in.valid && opt[RTGO_BIT13_SEL_POS]) |=>
    (info_out.word[13] == $past(info_in.broadcast)))
    else $error("bit 13 is not the broadcast flag");

  a_info_kept_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && info_in.valid) |=> (info_out.word[15:14] == $past(info_in.word[15:14])
    && info_out.word[12:0] == $past(info_in.word[12:0])))
    else $error("information word bits other than 13 were altered");

  a_info_no_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !info_in.valid) |=> !info_out.valid)
    else $error("information word stored without a request");

  // Log buffer identity word.
  a_busy_seen_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_busy_logged |=> (log_out.write && log_out.word[9]))
    else $error("busy seen bit not set while busy");

  a_busy_seen_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && evt.valid && !term_busy) |=>
    (!log_out.word[9] && log_out.word[8:0] == $past(evt.flags[8:0])))
    else $error("busy seen bit set while not busy");

  a_busy_rpt_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && evt.valid && !opt[RTGO_BUSY_RPT_POS]) |=> !log_out.word[9])
    else $error("busy seen bit set with reporting off");

  a_log_on_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && evt.valid) |=> (log_out.write && log_out.word[15:10] == $past(evt.flags[15:10])
    && log_out.word[8:0] == $past(evt.flags[8:0])))
    else $error("enabled event did not write its flags to the log");

  a_no_busy_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !evt.valid && term_busy) |=> !log_out.write)
    else $error("log entry without an enabled event");

  a_log_word_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !evt.valid) |=> $stable(log_out.word))
    else $error("log word changed without an event");

  // Pending register, clock enable and reset.
  a_pend_rsvd: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce |=> (!pend_out[9] && pend_out[8:0] == $past(pend_in[8:0])))
    else $error("pending register bit 9 not reserved");

  a_ce_hold_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ce |=> ($stable(opt) && $stable(acc_rdata)))
    else $error("register state moved while the clock enable was low");

  a_ce_hold_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ce |=> ($stable(log_out) && $stable(info_out) && $stable(pend_out)))
    else $error("outputs moved while the clock enable was low");

  a_reset_zero: assert property (@(posedge core_clk)
    $rose(rst_n) |-> (opt == RTGO_OPT_RESET))
    else $error("option register not zero after reset");
endmodule

// ==== rtgo_pkg.sv ====
// Package of constants and carrier types for the remote terminal global option register.
package rtgo_pkg;
  localparam logic [15:0] RTGO_OPT_ADDR = 16'h004d;
  localparam logic [15:0] RTGO_OPT_RESET = 16'h0000;
  localparam logic [15:0] RTGO_OPT_WMASK = 16'h003f;
  localparam int RTGO_BIT13_SEL_POS = 3;
  localparam int RTGO_BUSY_RPT_POS = 2;
  localparam int RTGO_PTR_HOLD_POS = 1;
  localparam int RTGO_OPT0_POS = 0;
  localparam int RTGO_INFO_FLAG_POS = 13;
  localparam int RTGO_BUSY_SEEN_POS = 9;
  localparam int RTGO_PEND_RSVD_POS = 9;

  // One host access to the register space, taken in one cycle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rtgo_acc_s;

  // One enabled interrupt event with its event flags.
  typedef struct packed {
    logic valid;
    logic [15:0] flags;
  } rtgo_event_s;

  // One message information word to be stored, with both candidate bit 13 sources.
  typedef struct packed {
    logic valid;
    logic gap_error;
    logic broadcast;
    logic [15:0] word;
  } rtgo_info_s;

  // One log buffer write.
  typedef struct packed {
    logic write;
    logic [15:0] word;
  } rtgo_log_s;
endpackage

// ==== testbench.sv ====
// Self-checking testbench for the remote terminal global option register.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rtgo_pkg::*;
  logic core_clk = 0, rst_n = 0, ce = 1, term_busy = 0, rd_d = 0, phe, o0;
  rtgo_acc_s acc;
  rtgo_event_s evt = '0;
  rtgo_info_s info_in = '0, info_out;
  rtgo_log_s log_out;
  logic [15:0] acc_rdata, pend_in = '0, pend_out, r, opt;
  logic [15:0] exp_q[$];
  int bad_count = 0, samples_checked = 0;
  initial forever #50 core_clk = ~core_clk;
  rtgo_host_model i_rtgo_host_model (.core_clk(core_clk), .acc(acc));
  rtgo_option_reg i_rtgo_option_reg (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .acc(acc),
    .acc_rdata(acc_rdata), .term_busy(term_busy), .evt(evt), .log_out(log_out),
    .info_in(info_in), .info_out(info_out), .pend_in(pend_in), .pend_out(pend_out),
    .ptr_hold_enable(phe), .opt0(o0));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // An output with no note waiting pops unknown, so any stray result is a mismatch.
  function automatic logic [15:0] pop();
    return exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
  endfunction
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) rd_d <= acc.rd;
  always @(negedge core_clk)
  begin
    if (rd_d === 1'b1) check("acc_rdata", acc_rdata, pop());
    if (log_out.write === 1'b1) check("log_word", log_out.word, pop());
    if (info_out.valid === 1'b1) check("info_word", info_out.word, pop());
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(53));
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    exp_q.push_back(RTGO_OPT_RESET);
    i_rtgo_host_model.rd(RTGO_OPT_ADDR);
    repeat (4)
    begin
      r = $urandom;
      exp_q.push_back(r & 16'h000f);
      i_rtgo_host_model.wr(RTGO_OPT_ADDR, r);
      i_rtgo_host_model.wr(RTGO_OPT_ADDR + 16'h0001, 16'hffff);
      i_rtgo_host_model.rd(RTGO_OPT_ADDR);
      exp_q.push_back(16'h0000);
      i_rtgo_host_model.rd(RTGO_OPT_ADDR - 16'h0001);
    end
    for (int k = 0; k < 4; k++)
    begin
      opt = 16'(k) << 2;
      i_rtgo_host_model.wr(RTGO_OPT_ADDR, opt | 16'(k));
      repeat (4)
      begin
        r = $urandom;
        @(posedge core_clk);
        term_busy <= r[0];
        evt <= '{1'b1, r};
        info_in <= '{1'b1, r[1], r[2], r};
        exp_q.push_back({r[15:10], r[0] & opt[2], r[8:0]});
        exp_q.push_back({r[15:14], opt[3] ? r[2] : r[1], r[12:0]});
        @(posedge core_clk);
        evt <= '0;
        info_in <= '0;
        pend_in <= r | 16'h0200;
        @(posedge core_clk);
        @(negedge core_clk);
        check("pend_out", pend_out, pend_in & 16'hfdff);
      end
      check("opt_low", {14'h0000, phe, o0}, 16'(k) & 16'h0003);
    end
    // A write while the clock enable is low must be dropped; the options stay at 0x000f.
    @(posedge core_clk);
    ce <= 1'b0;
    i_rtgo_host_model.wr(RTGO_OPT_ADDR, 16'h0000);
    ce <= 1'b1;
    exp_q.push_back(16'h000f);
    i_rtgo_host_model.rd(RTGO_OPT_ADDR);
    exp_q.push_back(16'h0005);
    i_rtgo_host_model.wr(RTGO_OPT_ADDR, 16'h0005);
    i_rtgo_host_model.rd(RTGO_OPT_ADDR);
    // A reset in mid-run must bring a nonzero register back to all options disabled.
    @(posedge core_clk);
    pend_in <= '0;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check("opt_low", {14'h0000, phe, o0}, 16'h0000);
    exp_q.push_back(RTGO_OPT_RESET);
    i_rtgo_host_model.rd(RTGO_OPT_ADDR);
    repeat (3) @(posedge core_clk);
    check("queue", 16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule
